//--- logic/mcc_pkg.sv
// Package for the Manchester / three-of-six symbol codec.
// Assumes an APB master with 32-bit data and byte addresses on an 8-bit bus.
package mcc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_DATA_LOW = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_DATA_MID = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_DATA_HIGH = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h14;

	// Control register bit positions
	localparam int CTRL_READY = 7;
	localparam int CTRL_ERROR = 6;
	localparam int CTRL_ENC = 5;
	localparam int CTRL_DEC = 4;
	localparam int CTRL_DMA = 2;
	localparam int CTRL_ENDIAN = 1;
	localparam int CTRL_MODE = 0;

	// Interrupt status / mask bit positions
	localparam int IRQ_DONE = 0;
	localparam int IRQ_DEC_ERR = 1;
	localparam int IRQ_W = 2;

	localparam logic MODE_MANCH = 1'b0;
	localparam logic MODE_TOS = 1'b1;
	localparam logic [1:0] MAN_ZERO = 2'h2;
	localparam logic [1:0] MAN_ONE = 2'h1;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Six-bit symbol for each nibble, index = nibble value
	localparam logic [15:0][5:0] TOS_SYM = {6'h29, 6'h32, 6'h31, 6'h34, 6'h23, 6'h26, 6'h25, 6'h2C,
		6'h13, 6'h1A, 6'h19, 6'h1C, 6'h0B, 6'h0E, 6'h0D, 6'h16};

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_CALC = 1'b1
	} mcc_phase_t;

	typedef struct packed {
		logic [ADDR_W-1:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [DATA_W-1:0] pwdata;
	} mcc_apb_req_t;

	typedef struct packed {
		mcc_phase_t phase;
		logic ready;
		logic error;
		logic encode_start_bit;
		logic dec;
		logic dma;
		logic endian;
		logic mode;
		logic [23:0] data;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [DATA_W-1:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} mcc_state_t;

	localparam mcc_state_t STATE_RESET = '0;

endpackage : mcc_pkg

//--- logic/mcc_encoder.sv
// Combinational encoder: Manchester (low byte) or three-of-six (mid and low bytes).
// Assumes the caller samples the result in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module mcc_encoder (
	input wire logic mode_in,
	input wire logic [23:0] data_in,
	output logic [23:0] result_out
);
	logic [15:0] man;
	logic [23:0] tos;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_man
			// Msb of the byte lands in the top pair
			assign man[2*i+1 -: 2] = data_in[i] ? mcc_pkg::MAN_ONE : mcc_pkg::MAN_ZERO;
		end
		for (i = 0; i < 4; i++) begin : g_tos
			assign tos[6*i+5 -: 6] = mcc_pkg::TOS_SYM[data_in[4*i+3 -: 4]];
		end
	endgenerate

	// High byte untouched in Manchester mode
	assign result_out = (mode_in == mcc_pkg::MODE_TOS) ? tos : {data_in[23:16], man};

endmodule : mcc_encoder
`default_nettype wire

//--- logic/mcc_decoder.sv
// Combinational decoder with validity check for both codes.
// Assumes the caller samples the result in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module mcc_decoder (
	input wire logic mode_in,
	input wire logic [23:0] data_in,
	output logic [23:0] result_out,
	output logic error_out
);
	logic [7:0] man_byte;
	logic [7:0] man_bad;
	logic [3:0] nib [4];
	logic [3:0] tos_bad;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_man
			assign man_byte[i] = (data_in[2*i+1 -: 2] == mcc_pkg::MAN_ONE);
			assign man_bad[i] = (data_in[2*i+1 -: 2] != mcc_pkg::MAN_ONE) &&
				(data_in[2*i+1 -: 2] != mcc_pkg::MAN_ZERO);
		end
		for (i = 0; i < 4; i++) begin : g_tos
			always_comb begin
				nib[i] = 4'h0;
				tos_bad[i] = 1'b1;
				for (int k = 0; k < 16; k++) begin
					if (data_in[6*i+5 -: 6] == mcc_pkg::TOS_SYM[k]) begin
						nib[i] = 4'(k);
						tos_bad[i] = 1'b0;
					end
				end
			end
		end
	endgenerate

	always_comb begin
		if (mode_in == mcc_pkg::MODE_TOS) begin
			error_out = |tos_bad;
			result_out = {mcc_pkg::BYTE_ZERO, nib[3], nib[2], nib[1], nib[0]};
			if (error_out) begin
				result_out = {mcc_pkg::BYTE_ZERO, mcc_pkg::BYTE_ALL_ONES, mcc_pkg::BYTE_ALL_ONES};
			end
		end else begin
			error_out = |man_bad;
			// Low byte forced to ones on any bad pair
			result_out = {data_in[23:16], mcc_pkg::BYTE_ZERO,
				error_out ? mcc_pkg::BYTE_ALL_ONES : man_byte};
		end
	end

endmodule : mcc_decoder
`default_nettype wire

//--- logic/mcc_codec.sv
// Top of the symbol codec: APB register slave, operation sequencer, interrupt.
// Assumes one 40 MHz clock, async active-high reset, an APB master on the same clock.
`timescale 1ns/1ps
`default_nettype none

module mcc_codec (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire mcc_pkg::mcc_apb_req_t apb_req_in,
	output logic [mcc_pkg::DATA_W-1:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic irq_out
);
	mcc_pkg::mcc_state_t s;
	mcc_pkg::mcc_state_t next_s;

	logic setup;
	logic access;
	logic wr_ctrl;
	logic start_req;
	logic [23:0] enc_result;
	logic [23:0] dec_result;
	logic dec_err;
	logic [7:0] ctrl_view;

	mcc_encoder u_encoder (
		.mode_in(s.mode),
		.data_in(s.data),
		.result_out(enc_result)
	);

	mcc_decoder u_decoder (
		.mode_in(s.mode),
		.data_in(s.data),
		.result_out(dec_result),
		.error_out(dec_err)
	);

	assign setup = apb_req_in.psel && !apb_req_in.penable;
	// Access completes only on the cycle pready is shown
	assign access = apb_req_in.psel && apb_req_in.penable && s.pready;
	assign wr_ctrl = access && apb_req_in.pwrite && (apb_req_in.paddr == mcc_pkg::OFF_CTRL);
	assign start_req = wr_ctrl && (s.phase == mcc_pkg::ST_IDLE) &&
		(apb_req_in.pwdata[mcc_pkg::CTRL_ENC] || apb_req_in.pwdata[mcc_pkg::CTRL_DEC]);
	assign ctrl_view = {s.ready, s.error, s.encode_start_bit, s.dec, 1'b0, s.dma, s.endian, s.mode};

	always_comb begin
		next_s = s;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;

		// Answer is staged in setup so the access phase lasts one cycle
		if (setup) begin
			next_s.pready = 1'b1;
			next_s.prdata = '0;
			unique case (apb_req_in.paddr)
				mcc_pkg::OFF_CTRL: next_s.prdata[7:0] = ctrl_view;
				mcc_pkg::OFF_DATA_LOW: next_s.prdata[7:0] = s.data[7:0];
				mcc_pkg::OFF_DATA_MID: next_s.prdata[7:0] = s.data[15:8];
				mcc_pkg::OFF_DATA_HIGH: next_s.prdata[7:0] = s.data[23:16];
				mcc_pkg::OFF_IRQ_STATUS: next_s.prdata[mcc_pkg::IRQ_W-1:0] = s.irq_status;
				mcc_pkg::OFF_IRQ_MASK: next_s.prdata[mcc_pkg::IRQ_W-1:0] = s.irq_mask;
				default: next_s.pslverr = 1'b1;
			endcase
			if (apb_req_in.pwrite) begin
				next_s.prdata = '0;
			end
		end else if (access) begin
			next_s.pslverr = s.pslverr;
		end

		if (access && apb_req_in.pwrite) begin
			unique case (apb_req_in.paddr)
				mcc_pkg::OFF_CTRL: begin
					next_s.mode = apb_req_in.pwdata[mcc_pkg::CTRL_MODE];
					next_s.endian = apb_req_in.pwdata[mcc_pkg::CTRL_ENDIAN];
					next_s.dma = apb_req_in.pwdata[mcc_pkg::CTRL_DMA];
					// Flags can only be cleared by a write of zero
					if (!apb_req_in.pwdata[mcc_pkg::CTRL_READY]) begin
						next_s.ready = 1'b0;
					end
					if (!apb_req_in.pwdata[mcc_pkg::CTRL_ERROR]) begin
						next_s.error = 1'b0;
					end
					if (start_req) begin
						// Encode wins if both start bits are written
						next_s.encode_start_bit = apb_req_in.pwdata[mcc_pkg::CTRL_ENC];
						next_s.dec = !apb_req_in.pwdata[mcc_pkg::CTRL_ENC];
						next_s.phase = mcc_pkg::ST_CALC;
					end
				end
				mcc_pkg::OFF_DATA_LOW: next_s.data[7:0] = apb_req_in.pwdata[7:0];
				mcc_pkg::OFF_DATA_MID: next_s.data[15:8] = apb_req_in.pwdata[7:0];
				mcc_pkg::OFF_DATA_HIGH: next_s.data[23:16] = apb_req_in.pwdata[7:0];
				mcc_pkg::OFF_IRQ_STATUS: next_s.irq_status = s.irq_status & ~apb_req_in.pwdata[mcc_pkg::IRQ_W-1:0];
				mcc_pkg::OFF_IRQ_MASK: next_s.irq_mask = apb_req_in.pwdata[mcc_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end

		// Completion comes last so its sets win over a clear in the same cycle
		if (s.phase == mcc_pkg::ST_CALC) begin
			next_s.data = s.encode_start_bit ? enc_result : dec_result;
			next_s.ready = 1'b1;
			next_s.irq_status[mcc_pkg::IRQ_DONE] = 1'b1;
			if (s.dec && dec_err) begin
				next_s.error = 1'b1;
				next_s.irq_status[mcc_pkg::IRQ_DEC_ERR] = 1'b1;
			end
			next_s.encode_start_bit = 1'b0;
			next_s.dec = 1'b0;
			next_s.phase = mcc_pkg::ST_IDLE;
		end

		next_s.irq = |(next_s.irq_status & next_s.irq_mask);
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s <= mcc_pkg::STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign prdata_out = s.prdata;
	assign pready_out = s.pready;
	assign pslverr_out = s.pslverr;
	assign irq_out = s.irq;

	// Checks on the sequencer and the code tables
	logic calc_enc;
	logic calc_dec;
	assign calc_enc = (s.phase == mcc_pkg::ST_CALC) && s.encode_start_bit;
	assign calc_dec = (s.phase == mcc_pkg::ST_CALC) && s.dec;

	logic addr_mapped;
	assign addr_mapped = apb_req_in.paddr inside {mcc_pkg::OFF_CTRL, mcc_pkg::OFF_DATA_LOW, mcc_pkg::OFF_DATA_MID,
		mcc_pkg::OFF_DATA_HIGH, mcc_pkg::OFF_IRQ_STATUS, mcc_pkg::OFF_IRQ_MASK};

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	start_ready_a: assert property (start_req |=> (s.phase == mcc_pkg::ST_CALC) ##1 s.ready)
		else $error("operation start did not raise ready two cycles later");

	self_clear_a: assert property ((s.phase == mcc_pkg::ST_CALC) |=> !s.encode_start_bit && !s.dec
		&& (s.phase == mcc_pkg::ST_IDLE))
		else $error("start bits did not clear after operation");

	ready_sticky_a: assert property (s.ready && !(wr_ctrl && !apb_req_in.pwdata[mcc_pkg::CTRL_READY])
		|=> s.ready)
		else $error("ready flag dropped without a software clear");

	man_enc_a: assert property (calc_enc && !s.mode && s.data[7:0] == 8'hF0
		|=> s.data[15:0] == 16'h55AA)
		else $error("manchester encode of F0 not 55AA");

	man_dec_a: assert property (calc_dec && !s.mode && s.data[15:0] == 16'h55AA
		|=> s.data[15:0] == 16'h00F0)
		else $error("manchester decode of 55AA not F0");

	man_err_a: assert property (calc_dec && !s.mode && s.data[1:0] == 2'h3
		|=> s.data[7:0] == 8'hFF && s.error && s.irq_status[mcc_pkg::IRQ_DEC_ERR])
		else $error("bad manchester pair not flagged as FF with error");

	tos_enc_a: assert property (calc_enc && s.mode && s.data[15:0] == 16'h08F0
		|=> s.data == 24'h5ACA56)
		else $error("three-of-six encode of 08F0 wrong");

	tos_dec_a: assert property (calc_dec && s.mode && s.data == 24'h5ACA56
		|=> s.data == 24'h0008F0 && $stable(s.error))
		else $error("three-of-six decode of 5ACA56 wrong");

	tos_err_a: assert property (calc_dec && s.mode && s.data[5:0] == 6'h3F |=> s.error)
		else $error("bad six-bit symbol not flagged");

	high_unused_a: assert property ((s.phase == mcc_pkg::ST_CALC) && !s.mode
		|=> s.data[23:16] == $past(s.data[23:16]))
		else $error("high data byte changed in manchester mode");

	input_hold_a: assert property ((s.phase == mcc_pkg::ST_IDLE) && !(access && apb_req_in.pwrite)
		|=> $stable(s.data))
		else $error("data registers changed while idle without a write");

	irq_level_a: assert property (s.irq_status[mcc_pkg::IRQ_DONE] && s.irq_mask[mcc_pkg::IRQ_DONE]
		&& !access |=> irq_out)
		else $error("unmasked done status did not hold the interrupt");

	irq_quiet_a: assert property (((s.irq_status & s.irq_mask) == '0) && (s.phase == mcc_pkg::ST_IDLE)
		&& !access |=> !irq_out)
		else $error("interrupt raised with nothing unmasked pending");

	// Bus answer: exactly one access cycle, error only for holes in the map
	pready_setup_a: assert property (setup
		|=> pready_out)
		else $error("setup cycle was not answered by ready");

	pready_pulse_a: assert property (pready_out
		|=> !pready_out)
		else $error("ready stood longer than one access cycle");

	idle_no_ready_a: assert property (!setup
		|=> !pready_out)
		else $error("ready shown without a setup cycle");

	unmapped_err_a: assert property (setup && !addr_mapped
		|=> pslverr_out && (prdata_out == 32'h00000000))
		else $error("unmapped address not answered with an error");

	mapped_ok_a: assert property (setup && addr_mapped
		|=> !pslverr_out)
		else $error("mapped address answered with an error");

	write_rdata_a: assert property (setup && apb_req_in.pwrite
		|=> prdata_out == 32'h00000000)
		else $error("read data not zero during a write");

	ctrl_read_a: assert property (setup && !apb_req_in.pwrite && (apb_req_in.paddr == mcc_pkg::OFF_CTRL)
		|=> (prdata_out[31:8] == 24'h000000) && !prdata_out[3] && (prdata_out[7] == $past(s.ready))
		&& (prdata_out[0] == $past(s.mode)))
		else $error("control read back wrong");

	low_read_a: assert property (setup && !apb_req_in.pwrite && (apb_req_in.paddr == mcc_pkg::OFF_DATA_LOW)
		|=> prdata_out == {24'h000000, $past(s.data[7:0])})
		else $error("low data read back wrong");

	high_read_a: assert property (setup && !apb_req_in.pwrite && (apb_req_in.paddr == mcc_pkg::OFF_DATA_HIGH)
		|=> prdata_out == {24'h000000, $past(s.data[23:16])})
		else $error("high data read back wrong");

	// Register write paths; a busy cycle is left out as its result overwrites data
	low_write_a: assert property (access && apb_req_in.pwrite && (s.phase == mcc_pkg::ST_IDLE)
		&& (apb_req_in.paddr == mcc_pkg::OFF_DATA_LOW) |=> s.data[7:0] == $past(apb_req_in.pwdata[7:0]))
		else $error("low data write did not land");

	mid_write_a: assert property (access && apb_req_in.pwrite && (s.phase == mcc_pkg::ST_IDLE)
		&& (apb_req_in.paddr == mcc_pkg::OFF_DATA_MID) |=> s.data[15:8] == $past(apb_req_in.pwdata[7:0]))
		else $error("mid data write did not land");

	high_write_a: assert property (access && apb_req_in.pwrite && (s.phase == mcc_pkg::ST_IDLE)
		&& (apb_req_in.paddr == mcc_pkg::OFF_DATA_HIGH) |=> s.data[23:16] == $past(apb_req_in.pwdata[7:0]))
		else $error("high data write did not land");

	mode_write_a: assert property (wr_ctrl
		|=> s.mode == $past(apb_req_in.pwdata[mcc_pkg::CTRL_MODE]))
		else $error("mode bit not taken from control write");

	ctrl_store_a: assert property (wr_ctrl
		|=> (s.dma == $past(apb_req_in.pwdata[mcc_pkg::CTRL_DMA]))
		&& (s.endian == $past(apb_req_in.pwdata[mcc_pkg::CTRL_ENDIAN])))
		else $error("stored control bits not taken from control write");

	mask_write_a: assert property (access && apb_req_in.pwrite && (apb_req_in.paddr == mcc_pkg::OFF_IRQ_MASK)
		|=> s.irq_mask == $past(apb_req_in.pwdata[mcc_pkg::IRQ_W-1:0]))
		else $error("interrupt mask write did not land");

	status_clear_a: assert property (access && apb_req_in.pwrite && (s.phase == mcc_pkg::ST_IDLE)
		&& (apb_req_in.paddr == mcc_pkg::OFF_IRQ_STATUS)
		|=> (s.irq_status & $past(apb_req_in.pwdata[mcc_pkg::IRQ_W-1:0])) == '0)
		else $error("status bits written with one were not cleared");

	// Sequencer and flags
	enc_start_a: assert property (start_req && apb_req_in.pwdata[mcc_pkg::CTRL_ENC]
		|=> s.encode_start_bit && !s.dec)
		else $error("encode start not taken");

	dec_start_a: assert property (start_req && !apb_req_in.pwdata[mcc_pkg::CTRL_ENC]
		|=> s.dec && !s.encode_start_bit)
		else $error("decode start not taken");

	done_flags_a: assert property ((s.phase == mcc_pkg::ST_CALC)
		|=> s.ready && s.irq_status[mcc_pkg::IRQ_DONE])
		else $error("completion did not set ready and done status");

	ready_rise_a: assert property (!s.ready && (s.phase == mcc_pkg::ST_IDLE)
		|=> !s.ready)
		else $error("ready rose without a completed operation");

	error_sticky_a: assert property (s.error && !(wr_ctrl && !apb_req_in.pwdata[mcc_pkg::CTRL_ERROR])
		|=> s.error)
		else $error("error flag dropped without a software clear");

	enc_no_error_a: assert property (calc_enc && !s.error
		|=> !s.error)
		else $error("encode raised the error flag");

	// Code tables and byte placement
	man_mid_zero_a: assert property (calc_dec && !s.mode
		|=> s.data[15:8] == 8'h00)
		else $error("manchester decode left the mid byte set");

	tos_high_zero_a: assert property (calc_dec && s.mode
		|=> s.data[23:16] == 8'h00)
		else $error("three-of-six decode left the high byte set");

	man_enc_low_a: assert property (calc_enc && !s.mode && (s.data[7:0] == 8'h0F)
		|=> s.data[15:0] == 16'hAA55)
		else $error("manchester encode of 0F not AA55");

	man_enc_mix_a: assert property (calc_enc && !s.mode && (s.data[7:0] == 8'hA5)
		|=> s.data[15:0] == 16'h6699)
		else $error("manchester encode of A5 not 6699");

	man_dec_mix_a: assert property (calc_dec && !s.mode && (s.data[15:0] == 16'h6699)
		|=> s.data[7:0] == 8'hA5)
		else $error("manchester decode of 6699 not A5");

	tos_enc_low_a: assert property (calc_enc && s.mode && (s.data[15:0] == 16'h0123)
		|=> s.data == 24'h58D38B)
		else $error("three-of-six encode of 0123 wrong");

	tos_enc_high_a: assert property (calc_enc && s.mode && (s.data[15:0] == 16'hCDEF)
		|=> s.data == 24'hD31CA9)
		else $error("three-of-six encode of CDEF wrong");

	tos_err_out_a: assert property (calc_dec && s.mode && (s.data[5:0] == 6'h3F)
		|=> (s.data[15:0] == 16'hFFFF) && s.irq_status[mcc_pkg::IRQ_DEC_ERR])
		else $error("bad six-bit symbol did not force FFFF");

	enc_done_c: cover property (start_req ##2 s.ready && !s.error);
	dec_err_c: cover property (calc_dec ##1 s.error);
	clear_and_start_c: cover property (s.ready && start_req && !apb_req_in.pwdata[mcc_pkg::CTRL_READY]);
	tos_dec_c: cover property (calc_dec && s.mode ##1 s.ready);
	unmapped_c: cover property (setup && !addr_mapped ##1 pslverr_out);

endmodule : mcc_codec
`default_nettype wire

//--- sim/mcc_codec_bench.sv
// Self-checking bench for the symbol codec, driven over APB.
// Assumes the codec answers each access within a few cycles.
`timescale 1ns/1ps
`default_nettype none
module mcc_codec_bench;
	logic clk_in;
	logic rst_in;
	mcc_pkg::mcc_apb_req_t req;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic irq_out;
	int failures;
	int check_count;
	logic [31:0] rdat;
	logic rerr;
	logic [23:0] res;
	localparam logic [5:0] SYM [16] = '{6'h16, 6'h0D, 6'h0E, 6'h0B, 6'h1C, 6'h19, 6'h1A, 6'h13,
		6'h2C, 6'h25, 6'h26, 6'h23, 6'h34, 6'h31, 6'h32, 6'h29};

	mcc_codec DUT (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.apb_req_in(req),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.irq_out(irq_out)
	);

	function automatic logic [7:0] men(input logic [3:0] n);
		for (int i = 0; i < 4; i++) begin
			men[2*i+:2] = n[i] ? 2'h1 : 2'h2;
		end
	endfunction : men

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		check_count++;
		if (s !== x) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, s, x);
		end
	endtask : chk

	// Request held until pready is sampled; one idle edge after release
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		req.paddr <= a;
		req.pwrite <= w;
		req.pwdata <= d;
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		@(posedge clk_in);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) failures++;
		rdat = prdata_out;
		rerr = pslverr_out;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		@(posedge clk_in);
	endtask : xfer

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h00000000);
	endtask : rd

	task automatic rd3();
		rd(mcc_pkg::OFF_DATA_HIGH);
		res[23:16] = rdat[7:0];
		rd(mcc_pkg::OFF_DATA_MID);
		res[15:8] = rdat[7:0];
		rd(mcc_pkg::OFF_DATA_LOW);
		res[7:0] = rdat[7:0];
	endtask : rd3

	// Loads data, starts, polls ready; leaves last control read in rdat
	task automatic run(input logic [7:0] c, input logic [23:0] din);
		int n;
		wr(mcc_pkg::OFF_DATA_HIGH, {24'h0, din[23:16]});
		wr(mcc_pkg::OFF_DATA_MID, {24'h0, din[15:8]});
		wr(mcc_pkg::OFF_DATA_LOW, {24'h0, din[7:0]});
		rd(mcc_pkg::OFF_DATA_LOW);
		chk(rdat, {24'h0, din[7:0]});
		wr(mcc_pkg::OFF_CTRL, {24'h0, c});
		n = 0;
		do begin
			rd(mcc_pkg::OFF_CTRL);
			n++;
		end while (rdat[7] !== 1'b1 && n < 10);
	endtask : run

	task automatic t_reset();
		for (int a = 0; a < 24; a += 4) begin
			rd(8'(a));
			chk(rdat, 32'h00000000);
		end
		chk({31'h0, irq_out}, 32'h00000000);
	endtask : t_reset

	task automatic t_manch();
		logic [7:0] bs [4] = '{8'h0F, 8'hF0, 8'hA5, 8'h3C};
		foreach (bs[i]) begin
			run(8'h20, {8'h77, 8'h00, bs[i]});
			chk(rdat, 32'h00000080);
			rd3();
			chk({8'h0, res}, {16'h0077, men(bs[i][7:4]), men(bs[i][3:0])});
			rd(mcc_pkg::OFF_CTRL);
			chk(rdat, 32'h00000080);
			run(8'h10, res);
			chk(rdat, 32'h00000080);
			rd3();
			chk({8'h0, res}, {16'h0077, 8'h00, bs[i]});
		end
	endtask : t_manch

	task automatic t_tos();
		logic [15:0] ws [5] = '{16'h0123, 16'h4567, 16'h89AB, 16'hCDEF, 16'h08F0};
		foreach (ws[i]) begin
			run(8'h21, {8'h5A, ws[i]});
			chk(rdat, 32'h00000081);
			rd3();
			chk({8'h0, res}, {8'h0, SYM[ws[i][15:12]], SYM[ws[i][11:8]],
				SYM[ws[i][7:4]], SYM[ws[i][3:0]]});
			run(8'h11, res);
			chk(rdat, 32'h00000081);
			rd3();
			chk({8'h0, res}, {16'h0000, ws[i]});
		end
	endtask : t_tos

	task automatic t_err();
		wr(mcc_pkg::OFF_IRQ_MASK, 32'h00000003);
		run(8'h10, 24'h000003);
		chk(rdat, 32'h000000C0);
		rd(mcc_pkg::OFF_DATA_LOW);
		chk(rdat, 32'h000000FF);
		rd(mcc_pkg::OFF_IRQ_STATUS);
		chk(rdat, 32'h00000003);
		chk({31'h0, irq_out}, 32'h00000001);
		run(8'h10, {8'h00, 8'h55, 8'hAA});
		chk(rdat, 32'h00000080);
		rd(mcc_pkg::OFF_DATA_LOW);
		chk(rdat, 32'h000000F0);
		run(8'h11, 24'h00003F);
		chk(rdat, 32'h000000C1);
		rd3();
		chk({16'h0, res[15:0]}, 32'h0000FFFF);
		wr(mcc_pkg::OFF_IRQ_STATUS, 32'h00000003);
		rd(mcc_pkg::OFF_IRQ_STATUS);
		chk(rdat, 32'h00000000);
		chk({31'h0, irq_out}, 32'h00000000);
	endtask : t_err

	task automatic t_irq();
		wr(mcc_pkg::OFF_IRQ_MASK, 32'h00000000);
		run(8'h20, 24'h000012);
		chk({31'h0, irq_out}, 32'h00000000);
		wr(mcc_pkg::OFF_IRQ_MASK, 32'h00000001);
		rd(mcc_pkg::OFF_IRQ_STATUS);
		chk(rdat, 32'h00000001);
		chk({31'h0, irq_out}, 32'h00000001);
		wr(mcc_pkg::OFF_IRQ_STATUS, 32'h00000001);
		rd(mcc_pkg::OFF_IRQ_STATUS);
		chk(rdat, 32'h00000000);
		chk({31'h0, irq_out}, 32'h00000000);
	endtask : t_irq

	task automatic t_map();
		wr(8'h18, 32'h000000FF);
		chk({31'h0, rerr}, 32'h00000001);
		rd(8'h18);
		chk({rdat[30:0], rerr}, 32'h00000001);
	endtask : t_map

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		repeat (20000) @(posedge clk_in);
		failures++;
		print_verdict();
	end

	initial begin
		failures = 0;
		check_count = 0;
		req = '0;
		rst_in = 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		t_reset();
		t_manch();
		t_tos();
		t_err();
		t_irq();
		t_map();
		print_verdict();
	end
endmodule : mcc_codec_bench
`default_nettype wire
